/* src/scg_guard_top.sv */
// Purpose: etu divider, card clock, check-sum accumulator and tx guard timing
// Assumes: uart core on the same clock supplies bit strobes and char events
// Notes: bits handed in are logical (direct convention) data bits only
//
// Operation
// - card clock toggles on every intermediate tick, halving it.
// - etu pulse every 2*Fi/Di intermediate ticks from the selected codes.
// - divider value is clamped to at most 4096.
// - baud select holds Fi code in 7:4, Di code in 3:0, reset 0x11.
// - Fi codes map to 372..2048 per the fixed table.
// - Di codes map to 1..32, 12, 20, and 16 above.
// - integer divider per pair, rounded, within 1.1 percent.
// - crc uses polynomial x16 + x12 + x5 + 1.
// - residue 0x1D0F means crc ok; zero low byte means lrc ok.
// - lrc mode uses only accumulator bits 7:0.
// - t1 with check enable sends accumulator after the last data byte.
// - accumulator updates on every bit, readable always, enable or not.
// - crc runs on logical data, so convention does not change it.
// - received check bytes go to the receive fifo with data.
// - first tx char waits block guard time from last rx start bit.
// - block guard field bits 4:0 in etus, default 22, bits 6:5 unused.
// - block guard bit 7 is the msb of the 9-bit extra guard.
// - tx start bits spaced at least the extra guard time apart.
// - extra guard low byte defaults 12; floor 12 in t0, 11 in t1.
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
module scg_guard_top
  import scg_pkg::*;
(
  input wire logic i_clock, // 200 mhz system clock
  input wire logic i_reset, // async, active high
  input wire logic i_clock_en, // freezes all state when low
  input wire logic [15:0] i_addr, // register address
  input wire logic [7:0] i_wdata, // register write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  output logic [7:0] o_rdata, // read data, cycle after strobe
  input wire logic i_intermediate_tick, // intermediate clock enable pulse
  output logic o_card_clock, // smart card clock
  output logic o_etu_tick, // one pulse per etu
  input wire logic i_bit_strobe, // a data bit was sent or received
  input wire logic i_bit_value, // logical value of that bit
  input wire logic i_rx_start, // start bit of a received char
  input wire logic i_rx_char_valid, // received char complete
  input wire logic [7:0] i_rx_char, // received char, logical
  input wire logic i_tx_valid, // data char waiting to be sent
  input wire logic [7:0] i_tx_data, // that char
  input wire logic i_tx_last, // that char ends the message
  output logic o_tx_start, // begin sending o_tx_char now
  output logic [7:0] o_tx_char, // char to send
  output logic o_tx_check, // o_tx_char is a check byte
  output logic o_tx_busy, // check bytes pending, hold data
  output logic o_fifo_push, // push into receive fifo
  output logic [7:0] o_fifo_data // receive fifo data
);
  import scg_pkg::*;

  typedef struct packed {
    logic [7:0] baud;
    logic [15:0] acc;
    logic [7:0] block_guard_time;
    logic [7:0] extra_guard_time;
    logic [7:0] ctrl;
    logic [12:0] div_now;
    logic [12:0] div_cnt;
    logic card_clk;
    logic etu;
    logic [2:0] lrc_idx;
    logic [8:0] since_tx;
    logic [8:0] since_rx;
    logic rx_seen;
    scg_tx_state_t st;
    logic [7:0] chk_lo;
    logic tx_start;
    logic [7:0] tx_char;
    logic tx_chk;
    logic [7:0] rdata;
    logic fifo_push;
    logic [7:0] fifo_data;
  } scg_state_t;

  scg_state_t r;
  scg_state_t next_r;

  logic [8:0] egt_full;
  logic [8:0] egt_floor;
  logic [8:0] egt_eff;
  logic [8:0] bgt_eff;
  logic guard_open;
  logic lrc_mode;
  logic check_ok;
  logic [12:0] div_inc;
  logic crc_fb;
  logic [7:0] stat;

  always_comb begin
    egt_full = {r.block_guard_time[EGT_MSB], r.extra_guard_time};
    egt_floor = r.ctrl[CTRL_T1] ? EGT_MIN_T1 : EGT_MIN_T0;
    egt_eff = (egt_full < egt_floor) ? egt_floor : egt_full;
    bgt_eff = {4'h0, r.block_guard_time[BGT_HI:0]};
    // tx allowed once both spacing windows have passed
    guard_open = (r.since_tx >= egt_eff)
      && (!r.rx_seen || r.since_rx >= bgt_eff);
    lrc_mode = r.ctrl[CTRL_LRC];
    check_ok = lrc_mode ? (r.acc[7:0] == ZERO8) : (r.acc == CRC_GOOD);
    div_inc = r.div_cnt + DIV_ONE;
    crc_fb = r.acc[15] ^ i_bit_value;
    stat = ZERO8;
    stat[STAT_OPEN] = guard_open;
    stat[STAT_BUSY] = (r.st != ST_IDLE);
    stat[STAT_OK] = check_ok;

    next_r = r;
    next_r.etu = 1'b0;
    next_r.tx_start = 1'b0;
    next_r.fifo_push = 1'b0;
    next_r.rdata = ZERO8;

    // card clock and etu divider
    if (i_intermediate_tick) begin
      next_r.card_clk = ~r.card_clk;
      if (div_inc >= r.div_now) begin
        next_r.div_cnt = '0;
        next_r.etu = 1'b1;
        next_r.div_now = scg_divider(r.baud);
      end else begin
        next_r.div_cnt = div_inc;
      end
    end

    // etu counters since last tx and rx start bits, saturating
    if (r.etu) begin
      if (r.since_tx != ETU_SAT) begin
        next_r.since_tx = r.since_tx + 9'h001;
      end
      if (r.since_rx != ETU_SAT) begin
        next_r.since_rx = r.since_rx + 9'h001;
      end
    end
    if (i_rx_start) begin
      next_r.since_rx = '0;
      next_r.rx_seen = 1'b1;
      next_r.lrc_idx = '0;
    end

    // accumulator runs on every bit regardless of the enable
    if (i_bit_strobe) begin
      if (lrc_mode) begin
        next_r.acc[r.lrc_idx] = r.acc[r.lrc_idx] ^ i_bit_value;
        next_r.lrc_idx = r.lrc_idx + BIT_ONE;
      end else begin
        next_r.acc = {r.acc[14:0], 1'b0} ^ (crc_fb ? CRC_POLY : 16'h0000);
      end
    end

    // receive chars, check bytes included, pass to the fifo
    if (i_rx_char_valid) begin
      next_r.fifo_push = 1'b1;
      next_r.fifo_data = i_rx_char;
    end

    // transmit sequencing
    case (r.st)
      ST_IDLE: begin
        if (i_tx_valid && guard_open) begin
          next_r.tx_start = 1'b1;
          next_r.tx_char = i_tx_data;
          next_r.tx_chk = 1'b0;
          if (i_tx_last && r.ctrl[CTRL_T1] && r.ctrl[CTRL_CHKEN]) begin
            next_r.st = ST_CHK_HI;
          end
        end
      end
      ST_CHK_HI: begin
        if (guard_open) begin
          next_r.tx_start = 1'b1;
          next_r.tx_chk = 1'b1;
          next_r.chk_lo = r.acc[7:0];
          if (lrc_mode) begin
            next_r.tx_char = r.acc[7:0];
            next_r.st = ST_IDLE;
          end else begin
            next_r.tx_char = r.acc[15:8];
            next_r.st = ST_CHK_LO;
          end
        end
      end
      ST_CHK_LO: begin
        if (guard_open) begin
          next_r.tx_start = 1'b1;
          next_r.tx_chk = 1'b1;
          next_r.tx_char = r.chk_lo;
          next_r.st = ST_IDLE;
        end
      end
      default: begin
        next_r.st = ST_IDLE;
      end
    endcase
    if (next_r.tx_start) begin
      next_r.since_tx = '0;
      next_r.rx_seen = 1'b0;
      next_r.lrc_idx = '0;
    end

    // register writes; a firmware load overrides a bit update
    if (i_wr) begin
      case (i_addr)
        ADDR_BAUD: next_r.baud = i_wdata;
        ADDR_CHK_HI: begin
          next_r.acc[15:8] = i_wdata;
          next_r.lrc_idx = '0;
        end
        ADDR_CHK_LO: begin
          next_r.acc[7:0] = i_wdata;
          next_r.lrc_idx = '0;
        end
        ADDR_BGT: begin
          next_r.block_guard_time = ZERO8;
          next_r.block_guard_time[EGT_MSB] = i_wdata[EGT_MSB];
          next_r.block_guard_time[BGT_HI:0] = i_wdata[BGT_HI:0];
        end
        ADDR_EGT: next_r.extra_guard_time = i_wdata;
        ADDR_CTRL: begin
          next_r.ctrl = ZERO8;
          next_r.ctrl[CTRL_T1] = i_wdata[CTRL_T1];
          next_r.ctrl[CTRL_CHKEN] = i_wdata[CTRL_CHKEN];
          next_r.ctrl[CTRL_LRC] = i_wdata[CTRL_LRC];
        end
        default: begin
        end
      endcase
    end

    // register reads, data valid in the following cycle only
    if (i_rd) begin
      case (i_addr)
        ADDR_BAUD: next_r.rdata = r.baud;
        ADDR_CHK_HI: next_r.rdata = r.acc[15:8];
        ADDR_CHK_LO: next_r.rdata = r.acc[7:0];
        ADDR_BGT: next_r.rdata = r.block_guard_time;
        ADDR_EGT: next_r.rdata = r.extra_guard_time;
        ADDR_CTRL: next_r.rdata = r.ctrl;
        ADDR_STAT: next_r.rdata = stat;
        default: next_r.rdata = ZERO8;
      endcase
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      r.baud <= RST_BAUD;
      r.acc <= {RST_CHK, RST_CHK};
      r.block_guard_time <= RST_BGT;
      r.extra_guard_time <= RST_EGT;
      r.ctrl <= RST_CTRL;
      r.div_now <= 13'h02E8;
      r.div_cnt <= '0;
      r.card_clk <= 1'b0;
      r.etu <= 1'b0;
      r.lrc_idx <= '0;
      r.since_tx <= ETU_SAT;
      r.since_rx <= ETU_SAT;
      r.rx_seen <= 1'b0;
      r.st <= ST_IDLE;
      r.chk_lo <= ZERO8;
      r.tx_start <= 1'b0;
      r.tx_char <= ZERO8;
      r.tx_chk <= 1'b0;
      r.rdata <= ZERO8;
      r.fifo_push <= 1'b0;
      r.fifo_data <= ZERO8;
    end else if (i_clock_en) begin
      r <= next_r;
    end
  end

  assign o_rdata = r.rdata;
  assign o_card_clock = r.card_clk;
  assign o_etu_tick = r.etu;
  assign o_tx_start = r.tx_start;
  assign o_tx_char = r.tx_char;
  assign o_tx_check = r.tx_chk;
  assign o_tx_busy = (r.st != ST_IDLE) ? 1'b1 : 1'b0;
  assign o_fifo_push = r.fifo_push;
  assign o_fifo_data = r.fifo_data;
endmodule : scg_guard_top

/* inc/scg_pkg.sv */
// Purpose: constants and helpers for the smart card etu / check-sum / guard block
// Assumes: 16-bit register addresses, 8-bit register data
// Notes: divider values are rounded integers of 2*Fi/Di
package scg_pkg;
  localparam logic [15:0] ADDR_BAUD = 16'hFE13;
  localparam logic [15:0] ADDR_CHK_HI = 16'hFE14;
  localparam logic [15:0] ADDR_CHK_LO = 16'hFE15;
  localparam logic [15:0] ADDR_BGT = 16'hFE16;
  localparam logic [15:0] ADDR_EGT = 16'hFE17;
  localparam logic [15:0] ADDR_CTRL = 16'hFE30;
  localparam logic [15:0] ADDR_STAT = 16'hFE31;

  localparam logic [7:0] RST_BAUD = 8'h11;
  localparam logic [7:0] RST_CHK = 8'hFF;
  localparam logic [7:0] RST_BGT = 8'h16;
  localparam logic [7:0] RST_EGT = 8'h0C;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] ZERO8 = 8'h00;

  // field positions
  localparam int F_HI = 7;
  localparam int F_LO = 4;
  localparam int D_HI = 3;
  localparam int D_LO = 0;
  localparam int BGT_HI = 4;
  localparam int EGT_MSB = 7;
  localparam int CTRL_T1 = 0;
  localparam int CTRL_CHKEN = 1;
  localparam int CTRL_LRC = 2;
  localparam int STAT_OPEN = 0;
  localparam int STAT_BUSY = 1;
  localparam int STAT_OK = 2;

  localparam logic [8:0] EGT_MIN_T0 = 9'h00C;
  localparam logic [8:0] EGT_MIN_T1 = 9'h00B;
  localparam logic [8:0] ETU_SAT = 9'h1FF;
  localparam logic [12:0] DIV_MAX = 13'h1000;
  localparam logic [12:0] DIV_ONE = 13'h0001;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_GOOD = 16'h1D0F;
  localparam logic [2:0] BIT_ONE = 3'h1;

  typedef enum logic [1:0] {ST_IDLE, ST_CHK_HI, ST_CHK_LO} scg_tx_state_t;

  function automatic logic [11:0] scg_fi_ratio(input logic [3:0] c);
    case (c)
      4'h0, 4'h1: scg_fi_ratio = 12'd372;
      4'h2: scg_fi_ratio = 12'd558;
      4'h3: scg_fi_ratio = 12'd744;
      4'h4: scg_fi_ratio = 12'd1116;
      4'h5: scg_fi_ratio = 12'd1488;
      4'h6, 4'h7: scg_fi_ratio = 12'd1860;
      4'h8, 4'h9: scg_fi_ratio = 12'd512;
      4'hA: scg_fi_ratio = 12'd768;
      4'hB: scg_fi_ratio = 12'd1024;
      4'hC: scg_fi_ratio = 12'd1536;
      default: scg_fi_ratio = 12'd2048;
    endcase
  endfunction : scg_fi_ratio

  function automatic logic [5:0] scg_di_ratio(input logic [3:0] c);
    case (c)
      4'h0, 4'h1: scg_di_ratio = 6'd1;
      4'h2: scg_di_ratio = 6'd2;
      4'h3: scg_di_ratio = 6'd4;
      4'h4: scg_di_ratio = 6'd8;
      4'h5: scg_di_ratio = 6'd16;
      4'h6, 4'h7: scg_di_ratio = 6'd32;
      4'h8: scg_di_ratio = 6'd12;
      4'h9: scg_di_ratio = 6'd20;
      default: scg_di_ratio = 6'd16;
    endcase
  endfunction : scg_di_ratio

  // rounded 2*Fi/Di, clamped to the largest supported ratio
  function automatic logic [12:0] scg_divider(input logic [7:0] sel);
    logic [12:0] f2;
    logic [12:0] d;
    logic [12:0] v;
    f2 = {scg_fi_ratio(sel[F_HI:F_LO]), 1'b0};
    d = {7'h00, scg_di_ratio(sel[D_HI:D_LO])};
    v = (f2 + (d >> 1)) / d;
    if (v > DIV_MAX) begin
      v = DIV_MAX;
    end
    scg_divider = v;
  endfunction : scg_divider
endpackage : scg_pkg

/* verification/scg_guard_checker.sv */
// Purpose: port assertions for the etu, check-sum and guard block
// Assumes: checks are suspended while i_clock_en is low
// Notes: etu counts have one-etu resolution, so spacing allows one less
`timescale 1ns/1ps
module scg_guard_checker (
  input wire logic i_clock, // clock
  input wire logic i_reset, // async reset
  input wire logic i_clock_en, // clock enable
  input wire logic i_rd, // read strobe
  input wire logic i_intermediate_tick, // tick
  input wire logic i_rx_char_valid, // rx char
  input wire logic [7:0] i_rx_char, // rx data
  input wire logic i_tx_valid, // tx pending
  input wire logic [7:0] o_rdata, // read data
  input wire logic o_card_clock, // card clock
  input wire logic o_etu_tick, // etu pulse
  input wire logic o_tx_start, // tx start
  input wire logic o_tx_check, // check byte
  input wire logic o_tx_busy, // check pending
  input wire logic o_fifo_push, // fifo push
  input wire logic [7:0] o_fifo_data // fifo data
);
  logic [8:0] etu_cnt;
  logic seen;
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      etu_cnt <= 9'h000;
      seen <= 1'b0;
    end else if (!i_clock_en) begin
      etu_cnt <= etu_cnt;
    end else if (o_tx_start) begin
      etu_cnt <= 9'h000;
      seen <= 1'b1;
    end else if (o_etu_tick && etu_cnt != 9'h1FF) begin
      etu_cnt <= etu_cnt + 9'h001;
    end
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset || !i_clock_en);
  sequence s_data_start;
    o_tx_start && !o_tx_check;
  endsequence
  sequence s_check_start;
    o_tx_start && o_tx_check;
  endsequence
  chk_card_toggle: assert property (
    i_intermediate_tick |=> o_card_clock != $past(o_card_clock)) else $error("card clock stuck");
  chk_card_hold: assert property (
    !i_intermediate_tick |=> $stable(o_card_clock)) else $error("card clock moved");
  chk_etu_gap: assert property (
    o_etu_tick |=> !o_etu_tick [*8]) else $error("etu pulses too close");
  chk_etu_cause: assert property (
    o_etu_tick |-> $past(i_intermediate_tick)) else $error("etu without tick");
  chk_rdata_idle: assert property (
    !i_rd |=> o_rdata == 8'h00) else $error("read data not idle");
  chk_fifo_copy: assert property (
    i_rx_char_valid |=> o_fifo_push && o_fifo_data == $past(i_rx_char)) else $error("no push");
  chk_fifo_cause: assert property (
    o_fifo_push |-> $past(i_rx_char_valid)) else $error("stray push");
  chk_tx_spacing: assert property (
    o_tx_start && seen |-> etu_cnt >= 9'd10) else $error("tx starts too close");
  chk_busy_rise: assert property (
    $rose(o_tx_busy) |-> s_data_start) else $error("busy without data start");
  chk_check_busy: assert property (
    s_check_start |-> $past(o_tx_busy)) else $error("check byte while not busy");
  chk_start_cause: assert property (
    s_data_start |-> $past(i_tx_valid)) else $error("data start without request");
endmodule : scg_guard_checker
bind scg_guard_top scg_guard_checker u_chk (.i_clock, .i_reset, .i_clock_en, .i_rd,
  .i_intermediate_tick,
  .i_rx_char_valid, .i_rx_char, .i_tx_valid, .o_rdata, .o_card_clock, .o_etu_tick,
  .o_tx_start, .o_tx_check, .o_tx_busy, .o_fifo_push, .o_fifo_data);

/* verification/scg_card_model.sv */
// Purpose: card-side model: intermediate ticks and serial bit events
// Assumes: bits are handed over in logical form
// Notes: tick every cycle, or every other cycle when slow
`timescale 1ns/1ps
module scg_card_model (
  input wire logic i_clock, // system clock
  input wire logic i_slow, // halve tick rate
  output logic o_tick, // intermediate tick
  output logic o_bit_strobe, // bit event
  output logic o_bit_value, // bit value
  output logic o_rx_start, // start bit
  output logic o_rx_char_valid, // char done
  output logic [7:0] o_rx_char // char
);
  logic ph = 1'b0;
  always @(posedge i_clock) ph <= ~ph;
  assign o_tick = ~i_slow | ph;
  initial begin
    o_bit_strobe = 1'b0;
    o_bit_value = 1'b1;
    o_rx_start = 1'b0;
    o_rx_char_valid = 1'b0;
    o_rx_char = 8'h00;
  end
  task automatic bits(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      @(posedge i_clock);
      o_bit_strobe <= 1'b1;
      o_bit_value <= d[i];
      @(posedge i_clock);
      o_bit_strobe <= 1'b0;
      o_bit_value <= ~d[i];
    end
  endtask : bits
  task automatic rx(input logic [7:0] d);
    @(posedge i_clock);
    o_rx_start <= 1'b1;
    @(posedge i_clock);
    o_rx_start <= 1'b0;
    bits(d);
    @(posedge i_clock);
    o_rx_char_valid <= 1'b1;
    o_rx_char <= d;
    @(posedge i_clock);
    o_rx_char_valid <= 1'b0;
    o_rx_char <= ~d;
  endtask : rx
endmodule : scg_card_model

/* verification/testbench.sv */
// Purpose: register, etu, check-sum and guard scenarios
// Assumes: 200 mhz clock, clock enable held high except in the card clock freeze scenario
// Notes: etu 23 cycles for the guard scenarios
`timescale 1ns/1ps
module testbench;
  import scg_pkg::*;
  logic i_clock, i_reset, i_wr, i_rd, i_tx_valid, i_tx_last, slow, tick, bs, bv, rs, rv;
  logic clk_en;
  logic [15:0] i_addr, crc;
  logic [7:0] i_wdata, i_tx_data, o_rdata, o_tx_char, o_fifo_data, rc;
  logic o_card_clock, o_etu_tick, o_tx_start, o_tx_check, o_tx_busy, o_fifo_push;
  int err_total = 0;
  int checks = 0;
  int n;
  logic [7:0] sel [6] = '{8'h18, 8'h16, 8'h24, 8'h21, 8'hD1, 8'h16};
  int dv [6] = '{62, 23, 140, 1116, 4096, 46};
  scg_guard_top uut (.i_clock, .i_reset, .i_clock_en(clk_en), .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .i_intermediate_tick(tick), .o_card_clock, .o_etu_tick, .i_bit_strobe(bs),
    .i_bit_value(bv), .i_rx_start(rs), .i_rx_char_valid(rv), .i_rx_char(rc), .i_tx_valid,
    .i_tx_data, .i_tx_last, .o_tx_start, .o_tx_char, .o_tx_check, .o_tx_busy, .o_fifo_push,
    .o_fifo_data);
  scg_card_model card (.i_clock, .i_slow(slow), .o_tick(tick), .o_bit_strobe(bs),
    .o_bit_value(bv), .o_rx_start(rs), .o_rx_char_valid(rv), .o_rx_char(rc));
  task automatic print_verdict;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic rng(input int g, input int lo, input int hi);
    checks++;
    if (g < lo || g > hi) begin
      err_total++;
      $display("unexpected t=%0t got %h exp %h..%h", $time, g, lo, hi);
    end
  endtask : rng
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rdchk(input logic [15:0] a, input logic [7:0] e);
    @(posedge i_clock);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 chk({8'h00, o_rdata}, {8'h00, e});
  endtask : rdchk
  task automatic etu_period(output int c);
    c = 0;
    @(posedge i_clock iff o_etu_tick);
    do begin
      @(posedge i_clock);
      c++;
    end while (!o_etu_tick && c < 9000);
  endtask : etu_period
  task automatic wait_start(output int c);
    c = 0;
    do begin
      @(posedge i_clock);
      c++;
    end while (!o_tx_start && c < 9000);
  endtask : wait_start
  task automatic tx(input logic [7:0] d, input logic last, output int c);
    @(posedge i_clock);
    i_tx_valid <= 1'b1;
    i_tx_data <= d;
    i_tx_last <= last;
    wait_start(c);
    i_tx_valid <= 1'b0;
    chk({8'h00, o_tx_char}, {8'h00, d});
  endtask : tx
  task automatic feed(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ d[i]) ? 16'h1021 : 16'h0000);
    end
  endtask : feed
  initial begin
    i_clock = 1'b0;
    forever #2.5 i_clock = ~i_clock;
  end
  initial begin
    repeat (60000) @(posedge i_clock);
    err_total++;
    print_verdict();
  end
  initial begin
    i_reset = 1'b1;
    clk_en = 1'b1;
    i_addr = 16'h0000;
    i_wdata = 8'h00;
    {i_wr, i_rd, i_tx_valid, i_tx_last, slow} = 5'h00;
    i_tx_data = 8'h00;
    repeat (2) @(posedge i_clock);
    i_reset <= 1'b0;
    rdchk(ADDR_BAUD, 8'h11);
    rdchk(ADDR_CHK_HI, 8'hFF);
    rdchk(ADDR_CHK_LO, 8'hFF);
    rdchk(ADDR_BGT, 8'h16);
    rdchk(ADDR_EGT, 8'h0C);
    rdchk(16'hFE20, 8'h00);
    // clock enable low freezes the card clock
    @(posedge i_clock);
    clk_en <= 1'b0;
    @(posedge i_clock);
    #1 n = o_card_clock;
    repeat (4) @(posedge i_clock);
    #1 chk({15'h0000, o_card_clock}, n[15:0]);
    @(posedge i_clock);
    clk_en <= 1'b1;
    wr(ADDR_BGT, 8'hFF);
    rdchk(ADDR_BGT, 8'h9F);
    wr(ADDR_BGT, 8'h0A);
    for (int k = 0; k < 6; k++) begin
      slow <= (k == 5);
      wr(ADDR_BAUD, sel[k]);
      etu_period(n);
      etu_period(n);
      rng(n, dv[k], dv[k]);
    end
    slow <= 1'b0;
    wr(ADDR_BAUD, 8'h16);
    wr(ADDR_CHK_HI, 8'hFF);
    wr(ADDR_CHK_LO, 8'hFF);
    crc = 16'hFFFF;
    for (int k = 0; k < 3; k++) begin
      card.rx(8'h31 + 8'h75 * k[7:0]);
      feed(8'h31 + 8'h75 * k[7:0]);
    end
    rdchk(ADDR_CHK_HI, crc[15:8]);
    rdchk(ADDR_CHK_LO, crc[7:0]);
    card.rx(8'h55);
    tx(8'h6E, 1'b0, n);
    rng(n, 9 * 23 - 24, 11 * 23);
    tx(8'h5A, 1'b0, n);
    rng(n, 11 * 23, 13 * 23);
    wr(ADDR_CTRL, 8'h03);
    wr(ADDR_CHK_HI, 8'hFF);
    wr(ADDR_CHK_LO, 8'hFF);
    crc = 16'hFFFF;
    tx(8'hA5, 1'b1, n);
    #1 chk({15'h0000, o_tx_busy}, 16'h0001);
    card.bits(8'hA5);
    feed(8'hA5);
    wait_start(n);
    chk({o_tx_check, o_tx_char}, {1'b1, crc[15:8]});
    rng(n, 10 * 23 - 16, 12 * 23);
    wait_start(n);
    #1 chk({o_tx_check, o_tx_busy, o_tx_char}, {2'b10, crc[7:0]});
    wr(ADDR_CTRL, 8'h04);
    wr(ADDR_CHK_LO, 8'h00);
    card.rx(8'h3C);
    card.rx(8'h96);
    rdchk(ADDR_CHK_LO, 8'hAA);
    card.rx(8'hAA);
    rdchk(ADDR_CHK_LO, 8'h00);
    print_verdict();
  end
endmodule : testbench
